// ===== dri_defs.svh
// Purpose: constants for the dram init and mode register block
// Assumes: aclk at 20 MHz, period 50 ns
// Notes: offsets are byte addresses on the axi4-lite register bus
`ifndef DRI_DEFS_SVH
`define DRI_DEFS_SVH
// ****************************************
// timing
// ****************************************
`define DRI_CLK_NS 50
`define DRI_INIT_US 500
`define DRI_INIT_CYC ((`DRI_INIT_US * 1000) / `DRI_CLK_NS)
// ****************************************
// register offsets
// ****************************************
`define DRI_OFS_STATUS 12'h000
`define DRI_OFS_MR0 12'h004
`define DRI_OFS_MR1 12'h008
`define DRI_OFS_MR2 12'h00c
`define DRI_OFS_MR3 12'h010
`define DRI_OFS_LAST_ROW 12'h014
`define DRI_OFS_LAST_COL 12'h018
`define DRI_OFS_CTRL 12'h01c
// ****************************************
// mode register 0 and 1 fields
// ****************************************
`define DRI_MR0_BL_LSB 0
`define DRI_MR0_BT_BIT 3
`define DRI_MR0_TM_BIT 7
`define DRI_MR0_DLLRST_BIT 8
`define DRI_MR0_WR_LSB 9
`define DRI_MR1_AL_LSB 3
// ****************************************
// commands {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define DRI_CMD_ACT 4'h3
`define DRI_CMD_RD 4'h5
`define DRI_CMD_WR 4'h4
`define DRI_CMD_MRS 4'h0
`define DRI_CMD_ZQ 4'h6
`endif

// ===== dri_pkg.sv
// Purpose: types for the dram init and mode register block
// Assumes: dri_defs.svh holds the numbers
// Notes: none
package dri_pkg;
    typedef enum logic [2:0] {
        DRI_RESET, DRI_SELFINIT, DRI_WAIT_CKE, DRI_CONFIG, DRI_READY
    } dri_state_t;
endpackage

// ===== dri_mr0_decode.sv
// Purpose: decode mode register 0 and 1 into latencies and burst setup
// Assumes: mode registers hold standard ddr3 encodings
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "dri_defs.svh"
module dri_mr0_decode (
    // mode registers
    input wire logic [15:0] mr0,
    input wire logic [15:0] mr1,
    // decoded fields
    output logic [4:0] cas_lat,
    output logic [4:0] write_rec,
    output logic [5:0] read_lat,
    output logic [1:0] burst_mode,
    output logic interleave,
    output logic test_mode
);
    // ****************************************
    // field decode
    // ****************************************
    logic [3:0] cl_code;
    logic [2:0] wr_code;
    logic [4:0] al;
    // cl from a2 and a4..a6, whole clocks only
    always_comb begin
        cl_code = {mr0[6:4], mr0[2]};
        case (cl_code)
            4'h2: cas_lat = 5'h05;
            4'h4: cas_lat = 5'h06;
            4'h6: cas_lat = 5'h07;
            4'h8: cas_lat = 5'h08;
            4'ha: cas_lat = 5'h09;
            4'hc: cas_lat = 5'h0a;
            4'he: cas_lat = 5'h0b;
            4'h1: cas_lat = 5'h0c;
            4'h3: cas_lat = 5'h0d;
            4'h5: cas_lat = 5'h0e;
            default: cas_lat = 5'h00; // reserved code
        endcase
    end
    // write recovery from a9..a11
    always_comb begin
        wr_code = mr0[`DRI_MR0_WR_LSB +: 3];
        case (wr_code)
            3'h0: write_rec = 5'h10;
            3'h1: write_rec = 5'h05;
            3'h2: write_rec = 5'h06;
            3'h3: write_rec = 5'h07;
            3'h4: write_rec = 5'h08;
            3'h5: write_rec = 5'h0a;
            3'h6: write_rec = 5'h0c;
            default: write_rec = 5'h0e;
        endcase
    end
    // additive latency: 0, cl-1, cl-2
    always_comb begin
        case (mr1[`DRI_MR1_AL_LSB +: 2])
            2'h1: al = cas_lat - 5'h01;
            2'h2: al = cas_lat - 5'h02;
            default: al = 5'h00;
        endcase
    end
    assign read_lat = {1'b0, al} + {1'b0, cas_lat};
    assign burst_mode = mr0[`DRI_MR0_BL_LSB +: 2];
    assign interleave = mr0[`DRI_MR0_BT_BIT];
    assign test_mode = mr0[`DRI_MR0_TM_BIT]; // vendor only
endmodule
`default_nettype wire

// ===== dri_top.sv
// Purpose: dram-side init sequencing, mode registers and command decode
// Assumes: aclk 20 MHz; dram pins are asynchronous and synchronised here
// Notes: the dram clock is sampled and its rising edges strobe the command pins
//
// Functional notes
// - each access moves one 8n word in core as two n transfers per clock
// - bursts of eight or chopped four; activate must precede read or write
// - activate takes bank from three bank inputs and row from a0..a15
// - read/write take column, a10 auto precharge, a12 chop when on the fly
// - after reset release wait 500us before cke; device self-initialises
// - termination stays off during reset and until cke is first high
// - mode registers undefined at power-up; mode writes keep array contents
// - cas latency from a2,a4..a6 in whole clocks; read latency is al plus cl
// - burst length from a0..a1, burst type from a3
// - dll reset bit clears itself after the reset is done
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "dri_defs.svh"
module dri_top #(
    parameter int unsigned INIT_CYC = `DRI_INIT_CYC
) (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // dram pins from the controller
    input wire logic dram_ck,
    input wire logic dram_reset_n,
    input wire logic dram_cke,
    input wire logic dram_odt,
    input wire logic dram_cs_n,
    input wire logic dram_ras_n,
    input wire logic dram_cas_n,
    input wire logic dram_we_n,
    input wire logic [2:0] dram_ba,
    input wire logic [15:0] dram_addr,
    // device state
    output logic odt_enable,
    output logic init_done,
    output logic [1:0] core_beat
);
    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NS = 27;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    logic ck_prev;
    // two stages for every pin; only the second stage is read
    always_ff @(posedge aclk) begin
        sync_a <= {dram_ck, dram_reset_n, dram_cke, dram_odt, dram_cs_n, dram_ras_n,
                   dram_cas_n, dram_we_n, dram_ba, dram_addr};
        sync_b <= sync_a;
        ck_prev <= sync_b[26];
    end
    logic ck_s, rst_n_s, cke_s, odt_s, ck_rise;
    logic [3:0] cmd_s;
    logic [2:0] ba_s;
    logic [15:0] a_s;
    assign ck_s = sync_b[26];
    assign rst_n_s = sync_b[25];
    assign cke_s = sync_b[24];
    assign odt_s = sync_b[23];
    assign cmd_s = sync_b[22:19];
    assign ba_s = sync_b[18:16];
    assign a_s = sync_b[15:0];
    assign ck_rise = ck_s & ~ck_prev;
    // command valid only when cke was high on the previous and current edge
    logic cke_prev;
    logic cmd_ok;
    assign cmd_ok = ck_rise & cke_s & cke_prev & rst_n_s;
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_n_s) begin
            cke_prev <= 1'b0;
        end else if (ck_rise) begin
            cke_prev <= cke_s;
        end
    end
    // ****************************************
    // init sequencer
    // ****************************************
    dri_pkg::dri_state_t state;
    logic [15:0] init_cnt;
    logic dll_reset_pend;
    logic zq_seen;
    // self-init runs on aclk only, independent of the dram clock
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_n_s) begin
            state <= dri_pkg::DRI_RESET;
            init_cnt <= 16'h0000;
        end else begin
            case (state)
                dri_pkg::DRI_RESET: begin
                    state <= dri_pkg::DRI_SELFINIT;
                    init_cnt <= 16'h0000;
                end
                dri_pkg::DRI_SELFINIT: begin
                    if (init_cnt >= 16'(INIT_CYC - 1)) begin
                        state <= dri_pkg::DRI_WAIT_CKE;
                    end else begin
                        init_cnt <= init_cnt + 16'h0001;
                    end
                end
                dri_pkg::DRI_WAIT_CKE: begin
                    if (ck_rise && cke_s) begin
                        state <= dri_pkg::DRI_CONFIG;
                    end
                end
                dri_pkg::DRI_CONFIG: begin
                    if (zq_seen) begin
                        state <= dri_pkg::DRI_READY;
                    end
                end
                dri_pkg::DRI_READY: state <= dri_pkg::DRI_READY;
                default: state <= dri_pkg::DRI_RESET;
            endcase
        end
    end
    // termination held off until cke seen after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            odt_enable <= 1'b0;
        end else begin
            odt_enable <= (state == dri_pkg::DRI_CONFIG || state == dri_pkg::DRI_READY)
                          & odt_s;
        end
    end
    assign init_done = (state == dri_pkg::DRI_READY);
    // ****************************************
    // mode registers and command decode
    // ****************************************
    logic [15:0] mr0, mr1, mr2, mr3;
    logic [2:0] act_bank;
    logic [15:0] act_row;
    logic [7:0] bank_open;
    logic [9:0] last_col;
    logic last_ap, last_chop, last_rd, bad_order;
    logic [2:0] beat_cnt;
    logic ctrl_clr;
    function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] code);
        return cmd_ok && c == code;
    endfunction
    // mode writes keep array state untouched; values zero from aresetn until written
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mr0 <= 16'h0000;
            mr1 <= 16'h0000;
            mr2 <= 16'h0000;
            mr3 <= 16'h0000;
            dll_reset_pend <= 1'b0;
        end else begin
            if (is_cmd(cmd_s, `DRI_CMD_MRS) && ba_s[2] == 1'b0) begin
                case (ba_s[1:0])
                    2'h0: mr0 <= a_s;
                    2'h1: mr1 <= a_s;
                    2'h2: mr2 <= a_s;
                    default: mr3 <= a_s;
                endcase
                dll_reset_pend <= (ba_s[1:0] == 2'h0) & a_s[`DRI_MR0_DLLRST_BIT];
            end else if (dll_reset_pend) begin
                // dll reset carried out; bit returns to zero
                mr0[`DRI_MR0_DLLRST_BIT] <= 1'b0;
                dll_reset_pend <= 1'b0;
            end
        end
    end
    // zq long marks end of configuration
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_n_s) begin
            zq_seen <= 1'b0;
        end else if (is_cmd(cmd_s, `DRI_CMD_ZQ) && a_s[10]) begin
            zq_seen <= 1'b1;
        end
    end
    // activate and column commands
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_n_s) begin
            act_bank <= 3'h0;
            act_row <= 16'h0000;
            bank_open <= 8'h00;
            last_col <= 10'h000;
            last_ap <= 1'b0;
            last_chop <= 1'b0;
            last_rd <= 1'b0;
            bad_order <= 1'b0;
        end else begin
            // clear first, so that a set in the same cycle wins
            if (ctrl_clr) begin
                bad_order <= 1'b0;
            end
            if (is_cmd(cmd_s, `DRI_CMD_ACT)) begin
                act_bank <= ba_s;
                act_row <= a_s;
                bank_open[ba_s] <= 1'b1;
            end else if (is_cmd(cmd_s, `DRI_CMD_RD) || is_cmd(cmd_s, `DRI_CMD_WR)) begin
                last_col <= a_s[9:0];
                last_ap <= a_s[10];
                last_chop <= (mr0[1:0] == 2'h1) ? ~a_s[12] : (mr0[1:0] == 2'h2);
                last_rd <= cmd_s[0];
                if (!bank_open[ba_s]) begin
                    bad_order <= 1'b1;
                end
                if (a_s[10]) begin
                    bank_open[ba_s] <= 1'b0;
                end
            end
        end
    end
    // one core word spans four dram clocks, two pin beats each
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_n_s) begin
            beat_cnt <= 3'h0;
        end else if (is_cmd(cmd_s, `DRI_CMD_RD) || is_cmd(cmd_s, `DRI_CMD_WR)) begin
            beat_cnt <= 3'h4;
        end else if (ck_rise && beat_cnt != 3'h0) begin
            beat_cnt <= beat_cnt - 3'h1;
        end
    end
    assign core_beat = beat_cnt[1:0];
    // ****************************************
    // decoded timing fields
    // ****************************************
    logic [4:0] cas_lat, write_rec;
    logic [5:0] read_lat;
    logic [1:0] burst_mode;
    logic interleave, test_mode;
    dri_mr0_decode u_dec (
        .mr0(mr0),
        .mr1(mr1),
        .cas_lat(cas_lat),
        .write_rec(write_rec),
        .read_lat(read_lat),
        .burst_mode(burst_mode),
        .interleave(interleave),
        .test_mode(test_mode)
    );
    // ****************************************
    // axi4-lite slave
    // ****************************************
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    // take address and data in either order, answer once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic [31:0] wdata_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_q <= 32'h00000000;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
        end
    end
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_bresp = (aw_addr == `DRI_OFS_CTRL) ? 2'h0 : 2'h2;
    // control: writing bit 0 clears the order-error flag
    assign ctrl_clr = aw_held && w_held && !s_axi_bvalid && aw_addr == `DRI_OFS_CTRL
                      && wdata_q[0];
    // read side: one word per request, answer the cycle after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `DRI_OFS_STATUS: s_axi_rdata <= {read_lat, write_rec, cas_lat, 1'b0,
                                 test_mode, interleave, burst_mode, bad_order,
                                 odt_enable, init_done, state, 5'h00};
                `DRI_OFS_MR0: s_axi_rdata <= {16'h0000, mr0};
                `DRI_OFS_MR1: s_axi_rdata <= {16'h0000, mr1};
                `DRI_OFS_MR2: s_axi_rdata <= {16'h0000, mr2};
                `DRI_OFS_MR3: s_axi_rdata <= {16'h0000, mr3};
                `DRI_OFS_LAST_ROW: s_axi_rdata <= {13'h0000, act_bank, act_row};
                `DRI_OFS_LAST_COL: s_axi_rdata <= {19'h00000, last_rd, last_chop,
                                   last_ap, last_col};
                `DRI_OFS_CTRL: s_axi_rdata <= 32'h00000000;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2; // unmapped
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// ===== dri_monitor.sv
// Purpose: port checks for the dram init and mode register block
// Assumes: one aclk domain, aresetn synchronous and active low
// Notes: dram pins are synchronised inside, so bounds allow a few cycles
`timescale 1ns/100ps
`default_nettype none
module dri_monitor (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // dram side
    input wire logic dram_reset_n,
    input wire logic dram_cke,
    input wire logic odt_enable,
    input wire logic init_done,
    input wire logic [1:0] core_beat
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // register bus and core beat count
    // ****************************************
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_no_accept_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken busy");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h01c
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read ok");
    a_beat_count: assert property ($changed(core_beat) && core_beat != 2'h0 |->
        core_beat == $past(core_beat) - 2'h1) else $error("beat skipped");
    // ****************************************
    // init and termination
    // ****************************************
    a_odt_in_reset: assert property (!dram_reset_n [*6] |-> !odt_enable && !init_done)
        else $error("odt in reset");
    a_odt_needs_cke: assert property ($rose(odt_enable) |-> dram_cke && dram_reset_n)
        else $error("odt before cke");
    a_init_drop: assert property ($fell(dram_reset_n) |-> ##[1:6] !init_done)
        else $error("ready in reset");
    a_init_needs_cke: assert property ($rose(init_done) |-> dram_cke && dram_reset_n)
        else $error("ready no cke");
    // main scenarios
    c_init: cover property ($rose(init_done));
    c_odt: cover property ($rose(odt_enable));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
`default_nettype wire

// ===== dri_ctl_model.sv
// Purpose: behavioural memory controller driving the dram pins
// Assumes: dram clock period 400 ns, phase unrelated to aclk
// Notes: bank and address lines toggle on each falling clock edge while idle deselects the device
`timescale 1ns/100ps
`default_nettype none
`include "dri_defs.svh"
module dri_ctl_model #(
    parameter int INIT_NS = 1500
) (
    // dram pins toward the device
    output logic dram_ck,
    output logic dram_reset_n,
    output logic dram_cke,
    output logic dram_odt,
    output logic dram_cs_n,
    output logic dram_ras_n,
    output logic dram_cas_n,
    output logic dram_we_n,
    output logic [2:0] dram_ba,
    output logic [15:0] dram_addr
);
    logic ck_run;
    // ****************************************
    // clock, parked low outside the powered window
    // ****************************************
    initial begin
        ck_run = 1'b0;
        dram_ck = 1'b0;
        dram_reset_n = 1'b0;
        dram_cke = 1'b0;
        dram_odt = 1'b1;
        {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} = 4'hf;
        dram_ba = 3'h0;
        dram_addr = 16'h0;
        #13;
        forever begin
            #200;
            dram_ck = ck_run ? ~dram_ck : 1'b0;
        end
    end
    // command set up at falling edge, taken at next rise
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
        @(negedge dram_ck);
        {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} = c;
        dram_ba = b;
        dram_addr = a;
    endtask
    // deselect; stale lines never look like a valid command
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge dram_ck);
            dram_cs_n = 1'b1;
            dram_ba = ~dram_ba;
            dram_addr = ~dram_addr;
        end
    endtask
    // full init; rst_ns picks power-up or stable-power reset
    task automatic init_seq(input logic [15:0] m0, m1, m2, m3, input int rst_ns, input logic odt);
        ck_run = 1'b0;
        dram_odt = odt;
        dram_cke = 1'b0;
        dram_reset_n = 1'b0;
        #(rst_ns);
        dram_reset_n = 1'b1;
        #(INIT_NS);
        ck_run = 1'b1;
        idle(5);
        @(negedge dram_ck);
        dram_cke = 1'b1;
        idle(5);
        issue(`DRI_CMD_MRS, 3'h2, m2);
        idle(4);
        issue(`DRI_CMD_MRS, 3'h3, m3);
        idle(4);
        issue(`DRI_CMD_MRS, 3'h1, m1 & 16'hfffe);
        idle(4);
        issue(`DRI_CMD_MRS, 3'h0, (m0 | 16'h0100) & 16'hff7f);
        idle(4);
        issue(`DRI_CMD_ZQ, 3'h0, 16'h0400);
        idle(8);
    endtask
endmodule
`default_nettype wire

// ===== test_ddr3_init_mode_register.sv
// Purpose: self-checking bench for the dram init and mode register block
// Assumes: aclk 20 MHz, dram clock 400 ns from the controller model
// Notes: init count shortened to 20 cycles; status low byte not checked
`timescale 1ns/100ps
`default_nettype none
`include "dri_defs.svh"
module test_ddr3_init_mode_register;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } dri_exp_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, core_beat;
    logic dram_ck, dram_reset_n, dram_cke, dram_odt, dram_cs_n, dram_ras_n, dram_cas_n;
    logic dram_we_n, odt_enable, init_done;
    logic [2:0] dram_ba;
    logic [15:0] dram_addr;
    dri_exp_t rq[$];
    logic [1:0] wq[$];
    int err_count = 0, total_checks = 0, cyc = 0;
    // ****************************************
    // clock, design and controller model
    // ****************************************
    always #25 aclk = ~aclk;
    dri_top #(.INIT_CYC(20)) i_dut (.*);
    dri_ctl_model i_ctl (.*);
    // ****************************************
    // bus tasks and comparisons
    // ****************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp_rd(input logic [1:0] r, input logic [31:0] d);
        dri_exp_t e;
        e = rq.pop_front();
        total_checks++;
        if ((((d ^ e.d) & e.m) !== 32'h0) || (r !== e.r)) begin
            err_count++;
            $display("BAD t=%0t got %h %h exp %h %h", $time, r, d, e.r, e.d);
        end
    endtask
    task automatic cmp_wr(input logic [1:0] r);
        logic [1:0] e;
        e = wq.pop_front();
        total_checks++;
        if (r !== e) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, r, e);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, m, input logic [1:0] r);
        rq.push_back('{d, m, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // result watcher, takes the oldest note per answer
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            cmp_wr(s_axi_bresp);
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            cmp_rd(s_axi_rresp, s_axi_rdata);
    end
    // hang guard, well above the two init runs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            err_count++;
            conclude();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [15:0] m2, m3, row, col;
        logic [2:0] bk;
        m2 = 16'($urandom(32'hf8f8e696));
        m3 = 16'($urandom());
        bk = 3'($urandom());
        row = 16'($urandom());
        col = 16'($urandom()) & 16'h03ff;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        i_ctl.init_seq(16'h0529, 16'h0000, m2, m3, 200000, 1'b1);
        axi_rd(`DRI_OFS_MR0, 32'h0429, 32'hffff, 2'h0);
        axi_rd(`DRI_OFS_MR1, 32'h0, 32'hffff, 2'h0);
        axi_rd(`DRI_OFS_MR2, {16'h0, m2}, 32'hffff, 2'h0);
        axi_rd(`DRI_OFS_MR3, {16'h0, m3}, 32'hffff, 2'h0);
        axi_rd(`DRI_OFS_STATUS, {6'd6, 5'd6, 5'd6, 3'b001, 2'b01, 3'b011, 8'h0},
            32'hffffff00, 2'h0);
        i_ctl.issue(`DRI_CMD_ACT, bk, row);
        i_ctl.idle(2);
        i_ctl.issue(`DRI_CMD_WR, bk, col | 16'h1000);
        i_ctl.idle(2);
        i_ctl.issue(`DRI_CMD_RD, bk, col | 16'h0400);
        i_ctl.idle(4);
        axi_rd(`DRI_OFS_LAST_ROW, {13'h0, bk, row}, 32'h7ffff, 2'h0);
        axi_rd(`DRI_OFS_LAST_COL, {19'h0, 3'b111, col[9:0]}, 32'h1fff, 2'h0);
        axi_rd(`DRI_OFS_STATUS, 32'h0, 32'h400, 2'h0);
        i_ctl.issue(`DRI_CMD_RD, bk ^ 3'h1, col);
        i_ctl.idle(4);
        axi_rd(`DRI_OFS_STATUS, 32'h400, 32'h400, 2'h0);
        axi_wr(`DRI_OFS_CTRL, 32'h1, 2'h0);
        axi_rd(`DRI_OFS_STATUS, 32'h0, 32'h400, 2'h0);
        axi_wr(`DRI_OFS_MR0, 32'h0, 2'h2);
        axi_rd(`DRI_OFS_MR0, 32'h0429, 32'hffff, 2'h0);
        axi_rd(12'h020, 32'h0, 32'hffffffff, 2'h2);
        fork
            i_ctl.init_seq(16'h0115, 16'h0008, m3, m2, 100, 1'b0);
            begin
                #700;
                axi_rd(`DRI_OFS_STATUS, 32'h0, 32'h300, 2'h0);
            end
        join
        axi_rd(`DRI_OFS_STATUS, {6'd25, 5'd16, 5'd13, 3'b000, 2'b01, 3'b001, 8'h0},
            32'hffffff00, 2'h0);
        axi_rd(`DRI_OFS_MR2, {16'h0, m3}, 32'hffff, 2'h0);
        conclude();
    end
endmodule
bind dri_top dri_monitor i_mon (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .dram_reset_n, .dram_cke, .odt_enable, .init_done, .core_beat
);
`default_nettype wire
